// file: verilog/srs_pkg.sv
// constants, field layouts and types shared by the stepper run sequencer
// How it works
// - writing start bit one begins a run
// - start bit reads one while motor runs
// - parameters frozen during run, phase control live
// - control bits five to zero locked while running
// - start written while running is ignored
// - finished operation stops motor, clears start bit
// - writing zero requests stop; ignored when stopped
// - hard stop halts at once, no ramp
// - hard stop ignores interrupt stops
// - no hard stop, ramp enabled: ramp down
// - continuous repeats, otherwise run once then stop
// - continuous stops only on stop or interrupt
// - operation field selects steps, rotations, or both
// - counts taken from current direction's registers
// - step mode refuses zero step count
// - rotation mode refuses zero rotation count
// - combined mode needs steps or rotations nonzero
// - direction field: cw, ccw, cw-ccw, ccw-cw
// - reversal finishes first leg, then reverses
// - first start energizes first or fourth coil
// - reference step after power-up not counted
// - later starts hold stopped coil one period
// - no hard stop, no ramp: stop immediately
// - wave drive: one coil, fixed rotating order
package srs_pkg;

  localparam logic [7:0] RUN_CTRL_ADDR  = 8'h26;
  localparam logic [7:0] RUN_CTRL_RESET = 8'h00;
  localparam int         START_BIT      = 7;
  localparam int         RSVD_BIT       = 6;
  localparam int         CTL_MSB        = 5;

  typedef enum logic [1:0] {
    OP_STEPS    = 2'b00,
    OP_ROTS     = 2'b01,
    OP_BOTH     = 2'b10,
    OP_BOTH_ALT = 2'b11
  } srs_op_t;

  typedef enum logic [1:0] {
    DIR_CW     = 2'b00,
    DIR_CCW    = 2'b01,
    DIR_CW_CCW = 2'b10,
    DIR_CCW_CW = 2'b11
  } srs_dir_t;

  typedef enum logic [1:0] {
    DRV_WAVE = 2'b00,
    DRV_TWO  = 2'b01,
    DRV_HALF = 2'b10,
    DRV_RSVD = 2'b11
  } srs_drive_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_RAMP = 2'b10
  } srs_state_t;

  // bits 5:0 of the run-control register
  typedef struct packed {
    logic     hardStop;
    logic     cont;
    srs_op_t  op;
    srs_dir_t dir;
  } srs_ctl_t;

  // motor parameter registers as seen by the sequencer
  typedef struct packed {
    logic [15:0] cwSteps;
    logic [7:0]  cwRots;
    logic [15:0] ccwSteps;
    logic [7:0]  ccwRots;
    logic        rampDownEn;
    logic [15:0] pulseWidth;
  } srs_params_t;

  localparam logic [2:0] POS_CW_FIRST  = 3'h0;
  localparam logic [2:0] POS_CCW_FIRST = 3'h6;
  localparam logic [2:0] POS_FULL_INC  = 3'h2;
  localparam logic [2:0] POS_HALF_INC  = 3'h1;
  localparam logic [3:0] COIL_NONE     = 4'h0;

endpackage : srs_pkg

// file: verilog/srs_step_timer.sv
// step pulse timer: one-cycle enable each pulse-width period
`timescale 1ns/1ps
`default_nettype none
module srs_step_timer
  import srs_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         enable,
  input  wire logic         restart,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  logic [W-1:0] count_ff;
  logic [W-1:0] lastCnt;

  // a zero period behaves as one cycle so the timer never stalls
  assign lastCnt = (period == '0) ? '0 : period - W'(1);
  assign tick    = enable && !restart && (count_ff >= lastCnt);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else if (restart || !enable || tick) begin
      count_ff <= '0;
    end else begin
      count_ff <= count_ff + W'(1);
    end
  end

endmodule : srs_step_timer
`default_nettype wire

// file: verilog/srs_stepper_run_sequencer.sv
// run-control sequencer: start/stop, counts, reversal and coil phasing
`timescale 1ns/1ps
`default_nettype none
module srs_stepper_run_sequencer
  import srs_pkg::*;
#(
  parameter int STEP_W          = 16,
  parameter int ROT_W           = 8,
  parameter int STEPS_PER_ROT   = 48,
  parameter int RAMP_DOWN_STEPS = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData,
  input  wire srs_params_t motorParams,
  input  wire logic [1:0]  phaseControl,
  input  wire logic        intStopReq,
  output logic      [3:0]  coilOut,
  output logic             motorRunning,
  output logic             runCcw
);

  srs_state_t  state_ff;
  srs_state_t  nxt_state;
  srs_ctl_t    ctl_ff;
  srs_params_t lat_ff;
  logic        ccw_ff;
  logic        secondLeg_ff;
  logic        firstStart_ff;
  logic [STEP_W-1:0] stepRem_ff;
  logic [ROT_W-1:0]  rotRem_ff;
  logic [15:0]       rotSub_ff;
  logic [15:0]       rampRem_ff;
  logic [2:0]        pos_ff;
  logic [3:0]        coil_ff;
  logic [7:0]        rdData_ff;
  logic              running_ff;

  srs_ctl_t   wrCtl;
  srs_drive_t drive;
  logic       wrRun;
  logic       startOk;
  logic       startReq;
  logic       stopReq;
  logic       tick;
  logic       runTick;
  logic       legDone;
  logic       reversal;
  logic       firstCcw;
  logic       loadLeg;
  logic       loadCcw;
  logic       endRun;
  logic       toRamp;
  logic       toIdle;
  logic [2:0] posInc;
  logic [3:0] nxt_coil;

  localparam logic [15:0] SPR_LAST  = 16'(STEPS_PER_ROT - 1);
  localparam logic [15:0] RAMP_LOAD = 16'(RAMP_DOWN_STEPS);

  // a direction leg may start only if its counts suit the operation
  function automatic logic legOk(srs_op_t op, logic [STEP_W-1:0] steps,
                                 logic [ROT_W-1:0] rots);
    logic ok;
    ok = 1'b0;
    case (op)
      OP_STEPS: ok = (steps != '0);
      OP_ROTS:  ok = (rots != '0);
      default:  ok = (steps != '0) || (rots != '0);
    endcase
    return ok;
  endfunction : legOk

  assign wrCtl    = srs_ctl_t'(regWrData[CTL_MSB:0]);
  assign wrRun    = regWrEn && (regAddr == RUN_CTRL_ADDR);
  assign drive    = srs_drive_t'(phaseControl);
  assign reversal = ctl_ff.dir[1];
  assign firstCcw = (ctl_ff.dir == DIR_CCW) || (ctl_ff.dir == DIR_CCW_CW);

  // start check uses the values being written and the live parameters
  always_comb begin
    startOk = 1'b0;
    case (wrCtl.dir)
      DIR_CW:  startOk = legOk(wrCtl.op, motorParams.cwSteps, motorParams.cwRots);
      DIR_CCW: startOk = legOk(wrCtl.op, motorParams.ccwSteps, motorParams.ccwRots);
      default: startOk = legOk(wrCtl.op, motorParams.cwSteps, motorParams.cwRots) &&
                         legOk(wrCtl.op, motorParams.ccwSteps, motorParams.ccwRots);
    endcase
  end

  // a start while busy and a stop while idle are both dropped
  assign startReq = wrRun && regWrData[START_BIT] && (state_ff == ST_IDLE)
                    && startOk;
  assign stopReq  = wrRun && !regWrData[START_BIT] && (state_ff != ST_IDLE);

  // restarting on every accepted start gives the held coil one full period
  srs_step_timer #(
    .W (16)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .enable  (state_ff != ST_IDLE),
    .restart (startReq),
    .period  (lat_ff.pulseWidth),
    .tick    (tick)
  );

  assign runTick = tick && (state_ff == ST_RUN);

  // leg ends on the tick that consumes its last counted step
  always_comb begin
    legDone = 1'b0;
    if (runTick) begin
      if (stepRem_ff != '0) begin
        legDone = (stepRem_ff == STEP_W'(1)) && (rotRem_ff == '0);
      end else begin
        legDone = (rotSub_ff == SPR_LAST) && (rotRem_ff == ROT_W'(1));
      end
    end
  end

  // what happens at the end of a leg
  always_comb begin
    loadLeg = 1'b0;
    loadCcw = ccw_ff;
    endRun  = 1'b0;
    if (legDone) begin
      if (reversal && !secondLeg_ff) begin
        loadLeg = 1'b1;
        loadCcw = !ccw_ff;
      end else if (ctl_ff.cont) begin
        loadLeg = 1'b1;
        loadCcw = firstCcw;
      end else begin
        endRun  = 1'b1;
      end
    end
  end

  // during ramp-down only a host stop with hard stop set cuts the ramp short
  // stop decisions; interrupt stops never look at the hard stop bit
  always_comb begin
    toRamp = 1'b0;
    toIdle = 1'b0;
    if (state_ff == ST_RUN) begin
      if (stopReq && ctl_ff.hardStop) begin
        toIdle = 1'b1;
      end else if (stopReq || intStopReq) begin
        toRamp = lat_ff.rampDownEn;
        toIdle = !lat_ff.rampDownEn;
      end else begin
        toIdle = endRun;
      end
    end else if (state_ff == ST_RAMP) begin
      toIdle = (stopReq && ctl_ff.hardStop) ||
               (tick && rampRem_ff <= 16'h0001);
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (startReq) begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        if (toIdle) begin
          nxt_state = ST_IDLE;
        end else if (toRamp) begin
          nxt_state = ST_RAMP;
        end
      end
      ST_RAMP: if (toIdle) begin
        nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // status pin from a flip-flop that tracks the state register edge for edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      running_ff <= 1'b0;
    end else begin
      running_ff <= (nxt_state != ST_IDLE);
    end
  end

  // control bits and parameters are taken only while stopped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_ff <= srs_ctl_t'(RUN_CTRL_RESET[CTL_MSB:0]);
    end else if (wrRun && state_ff == ST_IDLE) begin
      ctl_ff <= wrCtl;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lat_ff <= '0;
    end else if (startReq) begin
      lat_ff <= motorParams;
    end
  end

  // direction and leg tracking
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ccw_ff       <= 1'b0;
      secondLeg_ff <= 1'b0;
    end else if (startReq) begin
      ccw_ff       <= (wrCtl.dir == DIR_CCW) || (wrCtl.dir == DIR_CCW_CW);
      secondLeg_ff <= 1'b0;
    end else if (loadLeg) begin
      ccw_ff       <= loadCcw;
      secondLeg_ff <= reversal && !secondLeg_ff;
    end
  end

  // step and rotation counters, loaded from the direction's registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stepRem_ff <= '0;
      rotRem_ff  <= '0;
      rotSub_ff  <= '0;
    end else if (startReq) begin
      stepRem_ff <= '0;
      rotRem_ff  <= '0;
      rotSub_ff  <= '0;
      if (wrCtl.op != OP_ROTS) begin
        stepRem_ff <= wrCtl.dir[0] ? motorParams.ccwSteps : motorParams.cwSteps;
      end
      if (wrCtl.op != OP_STEPS) begin
        rotRem_ff  <= wrCtl.dir[0] ? motorParams.ccwRots : motorParams.cwRots;
      end
    end else if (loadLeg) begin
      stepRem_ff <= '0;
      rotRem_ff  <= '0;
      rotSub_ff  <= '0;
      if (ctl_ff.op != OP_ROTS) begin
        stepRem_ff <= loadCcw ? lat_ff.ccwSteps : lat_ff.cwSteps;
      end
      if (ctl_ff.op != OP_STEPS) begin
        rotRem_ff  <= loadCcw ? lat_ff.ccwRots : lat_ff.cwRots;
      end
    end else if (runTick) begin
      if (stepRem_ff != '0) begin
        stepRem_ff <= stepRem_ff - STEP_W'(1);
      end else if (rotSub_ff == SPR_LAST) begin
        rotSub_ff  <= '0;
        rotRem_ff  <= rotRem_ff - ROT_W'(1);
      end else begin
        rotSub_ff  <= rotSub_ff + 16'h0001;
      end
    end
  end

  // ramp-down moves a fixed number of uncounted steps
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rampRem_ff <= '0;
    end else if (toRamp) begin
      rampRem_ff <= RAMP_LOAD;
    end else if (tick && state_ff == ST_RAMP && rampRem_ff != '0) begin
      rampRem_ff <= rampRem_ff - 16'h0001;
    end
  end

  // the first tick after a start ends the hold period, so the held coil
  // (reference or last-stopped) is never counted as a step
  assign posInc = (drive == DRV_HALF) ? POS_HALF_INC : POS_FULL_INC;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      firstStart_ff <= 1'b1;
      pos_ff        <= POS_CW_FIRST;
    end else if (startReq) begin
      firstStart_ff <= 1'b0;
      if (firstStart_ff) begin
        pos_ff <= wrCtl.dir[0] ? POS_CCW_FIRST : POS_CW_FIRST;
      end
    end else if (tick) begin
      pos_ff <= ccw_ff ? pos_ff - posInc : pos_ff + posInc;
    end
  end

  // coil decode; phase control stays live during a run
  always_comb begin
    nxt_coil = COIL_NONE;
    case (drive)
      DRV_WAVE: nxt_coil = 4'h1 << pos_ff[2:1];
      DRV_TWO:  nxt_coil = (4'h1 << pos_ff[2:1]) |
                           (4'h1 << (pos_ff[2:1] + 2'h1));
      DRV_HALF: nxt_coil = pos_ff[0] ?
                           ((4'h1 << pos_ff[2:1]) | (4'h1 << (pos_ff[2:1] + 2'h1))) :
                           (4'h1 << pos_ff[2:1]);
      default:  nxt_coil = 4'h1 << pos_ff[2:1];
    endcase
  end

  // coils are dark until the first run, then hold the last coil
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      coil_ff <= COIL_NONE;
    end else if (state_ff != ST_IDLE || !firstStart_ff) begin
      coil_ff <= nxt_coil;
    end
  end

  // read data holds until the next read strobe; unmapped reads return zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= '0;
    end else if (regRdEn) begin
      rdData_ff <= '0;
      if (regAddr == RUN_CTRL_ADDR) begin
        rdData_ff[START_BIT]   <= (state_ff != ST_IDLE);
        rdData_ff[RSVD_BIT]    <= 1'b0;
        rdData_ff[CTL_MSB:0]   <= ctl_ff;
      end
    end
  end

  assign regRdData    = rdData_ff;
  assign coilOut      = coil_ff;
  assign motorRunning = running_ff;
  assign runCcw       = ccw_ff;

endmodule : srs_stepper_run_sequencer
`default_nettype wire

// file: testbench/srs_coil_load.sv
// coil driver load model: counts each change of the coil pattern
`timescale 1ns/1ps
`default_nettype none
module srs_coil_load (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  coilOut,
  output logic      [15:0] moves_ff
);
  logic [3:0] prevCoil_ff;
  // the drivers see one step per pattern change, reference step included
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prevCoil_ff <= 4'h0;
      moves_ff    <= 16'h0000;
    end else begin
      prevCoil_ff <= coilOut;
      if (coilOut != prevCoil_ff)
        moves_ff <= moves_ff + 16'h0001;
    end
  end
endmodule : srs_coil_load
`default_nettype wire

// file: testbench/srs_run_properties.sv
// port checker for the stepper run sequencer
`timescale 1ns/1ps
`default_nettype none
module srs_run_properties
  import srs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic        regWrEn,
  input wire logic [7:0]  regWrData,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  input wire srs_params_t motorParams,
  input wire logic [1:0]  phaseControl,
  input wire logic        intStopReq,
  input wire logic [3:0]  coilOut,
  input wire logic        motorRunning,
  input wire logic        runCcw
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic       wrCtl;
  logic       rdCtl;
  logic       startWr;
  logic       stopWr;
  logic [5:0] ctl_ff;
  logic       ramp_ff;
  logic       started_ff;
  assign wrCtl   = regWrEn && regAddr == RUN_CTRL_ADDR;
  assign rdCtl   = regRdEn && regAddr == RUN_CTRL_ADDR;
  assign startWr = wrCtl && regWrData[START_BIT];
  assign stopWr  = wrCtl && !regWrData[START_BIT] && motorRunning;
  // a refused start still updates the control copy, as the register does
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_ff     <= 6'h00;
      ramp_ff    <= 1'h0;
      started_ff <= 1'h0;
    end else begin
      if (wrCtl && !motorRunning)
        ctl_ff <= regWrData[5:0];
      if (startWr && !motorRunning)
        ramp_ff <= motorParams.rampDownEn;
      started_ff <= started_ff | motorRunning;
    end
  end
  start_write_a: assert property (
    $rose(motorRunning) |-> $past(startWr)) else $error("run began without start write");
  status_read_a: assert property (
    rdCtl |=> regRdData[7:6] == {$past(motorRunning), 1'h0}) else $error("bad status read");
  ctl_locked_a: assert property (
    rdCtl && motorRunning |=> regRdData[5:0] == ctl_ff) else $error("control bits moved");
  quick_stop_a: assert property (
    stopWr && (ctl_ff[5] || !ramp_ff) |=> !motorRunning) else $error("stop not immediate");
  ramp_stop_a: assert property (
    stopWr && !ctl_ff[5] && ramp_ff |=> motorRunning[*8]) else $error("ramp cut short");
  int_ramp_a: assert property (
    intStopReq && motorRunning && ramp_ff |=> motorRunning[*8]) else $error("int stop no ramp");
  first_coil_a: assert property (
    $rose(motorRunning) && !started_ff |-> ##[0:1] coilOut == (runCcw ? 4'h8 : 4'h1))
    else $error("wrong first coil");
  resume_coil_a: assert property (
    $rose(motorRunning) && started_ff |-> $stable(coilOut) ##1 $stable(coilOut))
    else $error("stopped coil not held");
  dir_select_a: assert property (
    $rose(motorRunning) |-> runCcw == ctl_ff[0]) else $error("wrong direction");
  wave_one_hot_a: assert property (
    motorRunning && $past(motorRunning) && $past(phaseControl) == 2'h0 |-> $onehot(coilOut))
    else $error("wave drive not one-hot");
endmodule : srs_run_properties
bind srs_stepper_run_sequencer srs_run_properties u_props (
  .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
  .motorParams(motorParams), .phaseControl(phaseControl), .intStopReq(intStopReq),
  .coilOut(coilOut), .motorRunning(motorRunning), .runCcw(runCcw));
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the stepper run sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srs_pkg::*;
  localparam int SPR = 48;
  logic        ref_clk = 1'h0;
  logic        rst = 1'h1;
  logic        regWrEn = 1'h0;
  logic        regRdEn = 1'h0;
  logic        intStopReq = 1'h0;
  logic        motorRunning;
  logic        runCcw;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic [1:0]  phaseCtl = 2'h0;
  logic [7:0]  regRdData;
  logic [7:0]  rd;
  logic [3:0]  coilOut;
  logic [15:0] moves_ff;
  logic [15:0] m0;
  logic [31:0] seed = 32'hDAAA;
  srs_params_t motorParams = '0;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          ex, cs, cr, qs, qr;
  logic [7:0]  runTab [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0B, 8'h0E};
  int          badTab [4][5] = '{'{0, 0, 3, 4, 4}, '{2, 5, 3, 0, 3},
                                 '{5, 3, 3, 5, 0}, '{10, 0, 0, 4, 2}};
  int          stopTab [4][4] = '{'{176, 1, 0, 0}, '{144, 1, 0, 8},
                                  '{144, 0, 0, 0}, '{176, 1, 1, 8}};

  always #2 ref_clk = ~ref_clk;

  srs_stepper_run_sequencer #(.STEPS_PER_ROT(SPR), .RAMP_DOWN_STEPS(8)) uut (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .motorParams(motorParams), .phaseControl(phaseCtl), .intStopReq(intStopReq),
    .coilOut(coilOut), .motorRunning(motorRunning), .runCcw(runCcw));
  srs_coil_load load (.ref_clk(ref_clk), .rst(rst), .coilOut(coilOut), .moves_ff(moves_ff));

  function automatic int rnd(input int n);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed[7:0]) % n;
  endfunction : rnd

  function automatic int leg(input logic [1:0] op, input int s, input int r);
    return (op == OP_STEPS) ? s : (op == OP_ROTS) ? r * SPR : s + r * SPR;
  endfunction : leg

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic setp(input int a, input int b, input int c, input int d, input logic ramp);
    motorParams.cwSteps    = 16'(a);
    motorParams.cwRots     = 8'(b);
    motorParams.ccwSteps   = 16'(c);
    motorParams.ccwRots    = 8'(d);
    motorParams.rampDownEn = ramp;
    motorParams.pulseWidth = 16'h0006;
  endtask : setp

  task automatic wr(input logic [7:0] d);
    @(negedge ref_clk);
    regAddr   = 8'h26;
    regWrData = d;
    regWrEn   = 1'h1;
    @(negedge ref_clk);
    regWrEn = 1'h0;
  endtask : wr

  task automatic rdr();
    @(negedge ref_clk);
    regAddr = 8'h26;
    regRdEn = 1'h1;
    @(negedge ref_clk);
    regRdEn = 1'h0;
    rd = regRdData;
  endtask : rdr

  task automatic wait_idle();
    for (int k = 0; k < 3000 && motorRunning !== 1'h0; k++)
      @(negedge ref_clk);
    // the load counts the last step two edges after the motor stops
    repeat (2) @(negedge ref_clk);
  endtask : wait_idle

  // a hung run still reaches the closing report
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end

  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 1'h0;
    rdr();
    chk("control reset", rd, 8'h00);
    // bit 6 is read-only and bit 7 low while idle asks for nothing
    wr(8'h40);
    rdr();
    chk("idle stop", rd, 8'h00);
    $display("test reset done");
    foreach (runTab[i]) begin
      cs = 4 + rnd(8);
      cr = 1 + rnd(2);
      qs = 4 + rnd(8);
      qr = 1 + rnd(2);
      setp(cs, cr, qs, qr, 1'h0);
      if (runTab[i][1])
        ex = leg(runTab[i][3:2], cs, cr) + leg(runTab[i][3:2], qs, qr);
      else
        ex = runTab[i][0] ? leg(runTab[i][3:2], qs, qr) : leg(runTab[i][3:2], cs, cr);
      if (i == 0)
        ex++;
      m0 = moves_ff;
      wr(8'h80 | runTab[i]);
      chk("direction", runCcw, runTab[i][0]);
      setp(0, 0, 0, 0, 1'h1);
      wr(8'hBF);
      rdr();
      chk("running ctl", rd, 8'h80 | runTab[i]);
      wait_idle();
      rdr();
      chk("done ctl", rd, runTab[i]);
      chk("steps", moves_ff - m0, ex);
      $display("test run %0d done", i);
    end
    for (int i = 0; i < 4; i++) begin
      setp(badTab[i][1], badTab[i][2], badTab[i][3], badTab[i][4], 1'h0);
      wr(8'h80 | 8'(badTab[i][0]));
      rdr();
      chk("refused start", rd[7], 1'h0);
    end
    $display("test refusal done");
    for (int i = 0; i < 4; i++) begin
      setp(2, 0, 2, 0, stopTab[i][1] != 0);
      wr(8'h80 | 8'(stopTab[i][0]));
      // stop lands 40 cycles after start, clear of the 6-cycle step ticks
      repeat (38) @(negedge ref_clk);
      chk("continuous", motorRunning, 1'h1);
      m0 = moves_ff;
      if (stopTab[i][2] != 0) begin
        @(negedge ref_clk);
        intStopReq = 1'h1;
        @(negedge ref_clk);
        intStopReq = 1'h0;
      end else
        wr(8'h00);
      wait_idle();
      chk("stop steps", moves_ff - m0, stopTab[i][3]);
      $display("test stop %0d done", i);
    end
    // drive format changes must reach the coils in the middle of a run
    setp(100, 0, 0, 0, 1'h0);
    wr(8'h80);
    repeat (3) @(negedge ref_clk);
    phaseCtl = 2'h1;
    @(negedge ref_clk);
    chk("two phase", $countones(coilOut), 32'h2);
    chk("phase run", motorRunning, 1'h1);
    phaseCtl = 2'h0;
    wr(8'h00);
    wait_idle();
    chk("phase stop", motorRunning, 1'h0);
    $display("test phase done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
